// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
   import wake_pkg::*;
   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   axil_req_type req = '0;
   axil_rsp_type rsp;
   logic         low_freq_osc = 1'b0;
   logic         high_freq_osc = 1'b0;
   logic [3:0]   pins = 4'h0;
   logic         in_range = 1'b0;
   logic         cold = 1'b0;
   logic         irq;
   logic         wake;
   logic         dev_rst;
   logic         lfo_en;
   logic         tpow;
   logic [2:0]   chan;
   logic [1:0]   mode;
   logic [31:0]  seed = 32'hE420ACC8;
   logic [31:0]  d;
   int           failures = 0;
   int           samples_checked = 0;
   int           cycles = 0;
   int           lfo_ticks = 0;
   int           hfo_ticks = 0;
   int           wakes = 0;
   int           resets = 0;
   int           t0;
   int           w0;

   periodic_wake_timer #(
      .DIV_WIDTH(8)
   ) i_dut (
      .clk_i              (clk_i),
      .rst_i              (rst_i),
      .axil_req_i         (req),
      .axil_rsp_o         (rsp),
      .low_freq_osc_i     (low_freq_osc),
      .high_freq_osc_i    (high_freq_osc),
      .port_a_pins_i      (pins),
      .temp_in_range_i    (in_range),
      .temp_cold_i        (cold),
      .irq_o              (irq),
      .wake_o             (wake),
      .device_reset_o     (dev_rst),
      .low_freq_osc_en_o  (lfo_en),
      .temp_sensor_power_o(tpow),
      .temp_channel_o     (chan),
      .power_mode_o       (mode)
   );

   always #5 clk_i = ~clk_i;

   // Oscillator ticks, event counts, hang guard
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles % 10 == 9)
      begin
         low_freq_osc <= ~low_freq_osc;
         if (!low_freq_osc) lfo_ticks <= lfo_ticks + 1;
      end
      if (cycles % 3 == 2)
      begin
         high_freq_osc <= ~high_freq_osc;
         if (!high_freq_osc) hfo_ticks <= hfo_ticks + 1;
      end
      if (wake === 1'b1) wakes <= wakes + 1;
      if (dev_rst === 1'b1) resets <= resets + 1;
      if (cycles == 60000)
      begin
         failures++;
         test_done();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Upper data bits carry random noise
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      logic        aw;
      logic        w;
      logic [31:0] r;
      aw = 1'b1;
      w = 1'b1;
      r = rnd();
      @(posedge clk_i);
      req.awaddr <= {16'h0000, a};
      req.awvalid <= 1'b1;
      req.wdata <= {r[31:8], v};
      req.wstrb <= 4'hF;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (aw && rsp.awready === 1'b1)
         begin
            aw = 1'b0;
            req.awvalid <= 1'b0;
         end
         if (w && rsp.wready === 1'b1)
         begin
            w = 1'b0;
            req.wvalid <= 1'b0;
         end
      end
      while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] q);
      logic ar;
      ar = 1'b1;
      @(posedge clk_i);
      req.araddr <= {16'h0000, a};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (ar && rsp.arready === 1'b1)
         begin
            ar = 1'b0;
            req.arvalid <= 1'b0;
         end
         q = rsp.rdata;
      end
      while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
   endtask

   task automatic rchk(input logic [15:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] q;
      rd(a, q);
      chk(q, exp, msg);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (irq !== 1'b1 && n < 6000);
   endtask

   task automatic wait_wake();
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wakes == w0 && n < 3000);
      repeat (3) @(posedge clk_i);
   endtask

   // Ticks between two successive flag sets
   task automatic measure(input logic [7:0] v, input int exp, input logic fast);
      wr(STATUS_CONTROL_ADDR, v | 8'h40);
      wait_irq();
      t0 = fast ? hfo_ticks : lfo_ticks;
      wr(STATUS_CONTROL_ADDR, v | 8'h40);
      wait_irq();
      chk((fast ? hfo_ticks : lfo_ticks) - t0, exp, "period");
   endtask

   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(STATUS_CONTROL_ADDR, 32'h0, "ctrl reset");
      rchk(OPTIONS_ADDR, 32'h0, "opt reset");
      rchk(WAKE_STATE_ADDR, 32'h0, "state reset");
      chk({31'h0, lfo_en}, 32'h1, "osc enable");
      chk({29'h0, chan}, TEMP_CHANNEL, "channel");
      $display("done: reset");
      wr(STATUS_CONTROL_ADDR, 8'h7F);
      rchk(STATUS_CONTROL_ADDR, 32'h37, "ctrl rw");
      wr(16'h1820, 8'hFF);
      rchk(16'h1820, 32'h0, "unmapped");
      rchk(STATUS_CONTROL_ADDR, 32'h37, "ctrl kept");
      $display("done: registers");
      for (int n = 1; n < 8; n++)
      begin
         measure(8'h10 | n[7:0], 2 << (n - 1), 1'b0);
         rchk(STATUS_CONTROL_ADDR, 32'h90 | n, "flag set");
         wr(STATUS_CONTROL_ADDR, n[7:0]);
         chk({31'h0, irq}, 32'h0, "irq masked");
         rchk(STATUS_CONTROL_ADDR, 32'h80 | n, "flag kept");
      end
      wr(STATUS_CONTROL_ADDR, 8'h40);
      repeat (300) @(posedge clk_i);
      rchk(STATUS_CONTROL_ADDR, 32'h0, "off");
      measure(8'h33, 8, 1'b1);
      wr(STATUS_CONTROL_ADDR, 8'h40);
      $display("done: periods");
      wr(STATUS_CONTROL_ADDR, 8'h42);
      w0 = wakes;
      wr(POWER_CMD_ADDR, {6'h00, CMD_LIGHT});
      chk({30'h0, mode}, 32'h1, "light");
      wait_wake();
      rchk(STATUS_CONTROL_ADDR, 32'h82, "light flag");
      chk({30'h0, mode}, 32'h0, "light exit");
      chk(resets, 32'h0, "no reset");
      $display("done: light sleep");
      wr(STATUS_CONTROL_ADDR, 8'h42);
      w0 = wakes;
      wr(POWER_CMD_ADDR, {6'h00, CMD_DEEP});
      chk({30'h0, mode}, 32'h2, "deep");
      wait_wake();
      rd(STATUS_CONTROL_ADDR, d);
      chk(d & 32'h80, 32'h0, "deep flag");
      chk(resets, 32'h1, "deep reset");
      wr(STATUS_CONTROL_ADDR, 8'h40);
      $display("done: deep sleep");
      wr(OPTIONS_ADDR, 8'h07);
      rchk(OPTIONS_ADDR, 32'h07, "options");
      chk({31'h0, tpow}, 32'h1, "sensor power");
      w0 = wakes;
      wr(POWER_CMD_ADDR, {6'h00, CMD_DEEP});
      repeat (50) @(posedge clk_i);
      chk(wakes, w0, "temp hold");
      in_range <= 1'b1;
      wait_wake();
      chk(resets, 32'h2, "temp reset");
      wr(OPTIONS_ADDR, 8'h01);
      w0 = wakes;
      wr(POWER_CMD_ADDR, {6'h00, CMD_DEEP});
      repeat (50) @(posedge clk_i);
      chk(wakes, w0, "cold hold");
      cold <= 1'b1;
      wait_wake();
      chk(resets, 32'h3, "cold reset");
      in_range <= 1'b0;
      cold <= 1'b0;
      $display("done: temperature");
      wr(OPTIONS_ADDR, 8'h10);
      w0 = wakes;
      wr(POWER_CMD_ADDR, {6'h00, CMD_LIGHT});
      pins <= 4'h2;
      repeat (50) @(posedge clk_i);
      chk(wakes, w0, "key masked");
      pins <= 4'h1;
      wait_wake();
      rchk(WAKE_STATE_ADDR, 32'h04, "keys");
      $display("done: keys");
      test_done();
   end
endmodule // tb

// ===== hdl/period_divider.sv
`timescale 1ns/1ns
// Tick counter: pulses once every (1 << sel) ticks of the chosen base
module period_divider #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic       clear_i,
   input  wire logic       tick_i,
   input  wire logic [2:0] sel_i,
   // Result
   output logic            elapsed_o
);
   import wake_pkg::*;
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             elapsed;
   } div_state_type;
   div_state_type state_reg;
   div_state_type state_next;
   logic [WIDTH-1:0] limit;
   always_comb
   begin
      limit      = WIDTH'((BASE_MS * LFO_TICKS_PER_MS) << (sel_i - 3'h1)) - WIDTH'(1);
      state_next = state_reg;
      state_next.elapsed = 1'b0;
      if (clear_i || sel_i == 3'h0)
      begin
         state_next.count = '0;
      end
      else if (tick_i)
      begin
         if (state_reg.count >= limit)
         begin
            state_next.count   = '0;
            state_next.elapsed = 1'b1;
         end
         else
         begin
            state_next.count = state_reg.count + WIDTH'(1);
         end
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end
   assign elapsed_o = state_reg.elapsed;
endmodule // period_divider

// ===== hdl/periodic_wake_timer.sv
`timescale 1ns/1ns
module periodic_wake_timer #(
   parameter int DIV_WIDTH = 8
) (
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // Register bus
   input  wire wake_pkg::axil_req_type axil_req_i,
   output wake_pkg::axil_rsp_type      axil_rsp_o,
   // Oscillator ticks and pins
   input  wire logic                   low_freq_osc_i,
   input  wire logic                   high_freq_osc_i,
   input  wire logic [3:0]             port_a_pins_i,
   input  wire logic                   temp_in_range_i,
   input  wire logic                   temp_cold_i,
   // System
   output logic                        irq_o,
   output logic                        wake_o,
   output logic                        device_reset_o,
   output logic                        low_freq_osc_en_o,
   output logic                        temp_sensor_power_o,
   output logic [2:0]                  temp_channel_o,
   output logic [1:0]                  power_mode_o
);
   import wake_pkg::*;
   typedef struct packed {
      logic [7:0]     ctrl;
      logic [7:0]     opts;
      power_mode_type mode;
      logic           aw_held;
      logic [15:0]    aw_addr;
      logic           w_held;
      logic [31:0]    w_data;
      logic [3:0]     w_strb;
      logic           bvalid;
      logic           rvalid;
      logic [31:0]    rdata;
      logic [6:0]     lf_sync;
      logic [6:0]     hf_sync;
      logic           wake;
      logic           dev_reset;
   } top_state_type;
   top_state_type state_reg;
   top_state_type state_next;
   logic       elapsed;
   logic       lf_tick;
   logic       hf_tick;
   logic       tick;
   logic [3:0] keys;
   logic       key_wake;
   logic       temp_wake;
   logic       do_write;
   logic       restart;
   logic       cold_s;
   logic       range_s;
   // Two-flop synchronisers for pin inputs
   logic [1:0] lf_s, hf_s;
   logic [3:0] key_s1, key_s2;
   logic [1:0] rng_s, cold_ss;
   always_ff @(posedge clk_i)
   begin
      lf_s    <= {lf_s[0], low_freq_osc_i};
      hf_s    <= {hf_s[0], high_freq_osc_i};
      key_s1  <= port_a_pins_i;
      key_s2  <= key_s1;
      rng_s   <= {rng_s[0], temp_in_range_i};
      cold_ss <= {cold_ss[0], temp_cold_i};
   end
   assign keys    = key_s2;
   assign range_s = rng_s[1];
   assign cold_s  = cold_ss[1];
   function automatic logic rise(input logic [6:0] hist);
      rise = hist[0] & ~hist[1];
   endfunction
   assign lf_tick = rise(state_reg.lf_sync);
   assign hf_tick = rise(state_reg.hf_sync);
   // High-freq base valid only in run; falls back to low-freq otherwise
   assign tick = (state_reg.ctrl[CLKSEL_BIT] && state_reg.mode == MODE_RUN) ? hf_tick : lf_tick;
   period_divider #(.WIDTH(DIV_WIDTH)) u_div (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .clear_i   (restart),
      .tick_i    (tick),
      .sel_i     (state_reg.ctrl[PSEL_MSB:0]),
      .elapsed_o (elapsed)
   );
   assign key_wake  = |(keys & state_reg.opts[KEYEN_LSB+3:KEYEN_LSB] & 4'hF);
   // Polarity: 1 wakes from the hot side, 0 from the cold side
   assign temp_wake = state_reg.opts[TRE_BIT] && range_s &&
                      (state_reg.opts[TRH_BIT] ? !cold_s : cold_s);
   assign do_write  = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
   // New period code restarts the count from zero
   assign restart   = do_write && state_reg.w_strb[0] && state_reg.aw_addr == STATUS_CONTROL_ADDR &&
                      state_reg.w_data[PSEL_MSB:0] != state_reg.ctrl[PSEL_MSB:0];
   always_comb
   begin
      state_next = state_reg;
      state_next.lf_sync = {state_reg.lf_sync[5:0], lf_s[1]};
      state_next.hf_sync = {state_reg.hf_sync[5:0], hf_s[1]};
      state_next.wake      = 1'b0;
      state_next.dev_reset = 1'b0;
      if (axil_req_i.awvalid && !state_reg.aw_held)
      begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = axil_req_i.awaddr[15:0];
      end
      if (axil_req_i.wvalid && !state_reg.w_held)
      begin
         state_next.w_held = 1'b1;
         state_next.w_data = axil_req_i.wdata;
         state_next.w_strb = axil_req_i.wstrb;
      end
      if (do_write)
      begin
         state_next.aw_held = 1'b0;
         state_next.w_held  = 1'b0;
         state_next.bvalid  = 1'b1;
         if (state_reg.w_strb[0])
         begin
            unique case (state_reg.aw_addr)
               STATUS_CONTROL_ADDR:
               begin
                  state_next.ctrl[CLKSEL_BIT]   = state_reg.w_data[CLKSEL_BIT];
                  state_next.ctrl[IEN_BIT]      = state_reg.w_data[IEN_BIT];
                  state_next.ctrl[PSEL_MSB:0]   = state_reg.w_data[PSEL_MSB:0];
                  if (state_reg.w_data[ACK_BIT])
                  begin
                     state_next.ctrl[FLAG_BIT] = 1'b0;
                  end
               end
               OPTIONS_ADDR:
               begin
                  state_next.opts = {state_reg.w_data[7:4], 1'b0, state_reg.w_data[ADCEN_BIT:0]};
               end
               POWER_CMD_ADDR:
               begin
                  if (state_reg.w_data[1:0] == CMD_LIGHT)
                  begin
                     state_next.mode = MODE_LIGHT;
                  end
                  else if (state_reg.w_data[1:0] == CMD_DEEP)
                  begin
                     state_next.mode = MODE_DEEP;
                  end
               end
               default:
               begin
               end
            endcase
         end
      end
      if (state_reg.bvalid && axil_req_i.bready)
      begin
         state_next.bvalid = 1'b0;
      end
      if (axil_req_i.arvalid && !state_reg.rvalid)
      begin
         state_next.rvalid = 1'b1;
         unique case (axil_req_i.araddr[15:0])
            STATUS_CONTROL_ADDR: state_next.rdata = {24'h000000, state_reg.ctrl & 8'hB7};
            OPTIONS_ADDR:        state_next.rdata = {24'h000000, state_reg.opts};
            WAKE_STATE_ADDR:     state_next.rdata = {26'h0, keys, state_reg.mode};
            default:             state_next.rdata = 32'h00000000;
         endcase
      end
      else if (state_reg.rvalid && axil_req_i.rready)
      begin
         state_next.rvalid = 1'b0;
      end
      // Timer event: set wins over a same-cycle acknowledge
      if (elapsed && state_reg.ctrl[PSEL_MSB:0] != 3'h0)
      begin
         if (state_reg.mode != MODE_DEEP)
         begin
            state_next.ctrl[FLAG_BIT] = 1'b1;
         end
         if (state_reg.mode != MODE_RUN)
         begin
            state_next.wake = 1'b1;
         end
      end
      if (state_reg.mode != MODE_RUN && key_wake)
      begin
         state_next.wake = 1'b1;
      end
      if (state_reg.mode == MODE_DEEP && temp_wake)
      begin
         state_next.wake = 1'b1;
      end
      if (state_next.wake)
      begin
         state_next.mode = MODE_RUN;
         if (state_reg.mode == MODE_DEEP)
         begin
            state_next.dev_reset      = 1'b1;
            state_next.ctrl[FLAG_BIT] = 1'b0;
         end
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg      <= '0;
         state_reg.ctrl <= CTRL_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end
   always_comb
   begin
      axil_rsp_o         = '0;
      axil_rsp_o.awready = !state_reg.aw_held;
      axil_rsp_o.wready  = !state_reg.w_held;
      axil_rsp_o.bvalid  = state_reg.bvalid;
      axil_rsp_o.arready = !state_reg.rvalid;
      axil_rsp_o.rvalid  = state_reg.rvalid;
      axil_rsp_o.rdata   = state_reg.rdata;
   end
   assign irq_o               = state_reg.ctrl[FLAG_BIT] && state_reg.ctrl[IEN_BIT];
   assign wake_o              = state_reg.wake;
   assign device_reset_o      = state_reg.dev_reset;
   assign low_freq_osc_en_o   = 1'b1;
   assign temp_sensor_power_o = state_reg.opts[ADCEN_BIT];
   assign temp_channel_o      = 3'(TEMP_CHANNEL);
   assign power_mode_o        = state_reg.mode;

   property p_ack_clears;
      @(posedge clk_i) disable iff (rst_i)
      do_write && state_reg.w_strb[0] && state_reg.aw_addr == STATUS_CONTROL_ADDR && state_reg.w_data[ACK_BIT] &&
      !(elapsed && state_reg.ctrl[PSEL_MSB:0] != 3'h0) |=> !state_reg.ctrl[FLAG_BIT];
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("flag kept after acknowledge");
   property p_no_flag_deep;
      @(posedge clk_i) disable iff (rst_i)
      state_reg.mode == MODE_DEEP && !state_reg.ctrl[FLAG_BIT] |=> !state_reg.ctrl[FLAG_BIT];
   endproperty
   a_no_flag_deep: assert property (p_no_flag_deep) else $error("flag set in deepest sleep");
   property p_flag_set;
      @(posedge clk_i) disable iff (rst_i)
      elapsed && state_reg.ctrl[2:0] != 3'h0 && state_reg.mode == MODE_RUN |=> state_reg.ctrl[FLAG_BIT];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on elapse");
   property p_ack_reads_zero;
      @(posedge clk_i) disable iff (rst_i)
      axil_req_i.arvalid && !state_reg.rvalid && axil_req_i.araddr[15:0] == STATUS_CONTROL_ADDR
      |=> !state_reg.rdata[ACK_BIT];
   endproperty
   a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read one");
   property p_off_no_elapse;
      @(posedge clk_i) disable iff (rst_i)
      state_reg.ctrl[2:0] == 3'h0 ##1 state_reg.ctrl[2:0] == 3'h0 |-> !elapsed;
   endproperty
   a_off_no_elapse: assert property (p_off_no_elapse) else $error("elapse while off");
   property p_deep_reset;
      @(posedge clk_i) disable iff (rst_i)
      state_reg.mode == MODE_DEEP && state_next.wake |=> device_reset_o && !state_reg.ctrl[FLAG_BIT];
   endproperty
   a_deep_reset: assert property (p_deep_reset) else $error("deep exit without reset");
   property p_lfo_on;
      @(posedge clk_i) low_freq_osc_en_o;
   endproperty
   a_lfo_on: assert property (p_lfo_on) else $error("oscillator disabled");
   property p_temp_power;
      @(posedge clk_i) disable iff (rst_i)
      do_write && state_reg.w_strb[0] && state_reg.aw_addr == OPTIONS_ADDR
      |=> temp_sensor_power_o == $past(state_reg.w_data[ADCEN_BIT]) && temp_channel_o == 3'h1;
   endproperty
   a_temp_power: assert property (p_temp_power) else $error("sensor power mismatch");
   property p_hf_only_run;
      @(posedge clk_i) disable iff (rst_i)
      state_reg.mode != MODE_RUN |-> tick == lf_tick;
   endproperty
   a_hf_only_run: assert property (p_hf_only_run) else $error("high clock outside run");
   c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
   c_deep: cover property (@(posedge clk_i) disable iff (rst_i) $rose(device_reset_o));
   c_light_wake: cover property (@(posedge clk_i) disable iff (rst_i) state_reg.mode == MODE_LIGHT ##1 wake_o);
endmodule // periodic_wake_timer

// ===== hdl/wake_pkg.sv
package wake_pkg;
   // Register byte addresses
   localparam logic [15:0] STATUS_CONTROL_ADDR = 16'h1808;
   localparam logic [15:0] OPTIONS_ADDR        = 16'h1810;
   localparam logic [15:0] WAKE_STATE_ADDR     = 16'h1814;
   localparam logic [15:0] POWER_CMD_ADDR      = 16'h1818;
   // Status/control field positions
   localparam int FLAG_BIT   = 7;
   localparam int ACK_BIT    = 6;
   localparam int CLKSEL_BIT = 5;
   localparam int IEN_BIT    = 4;
   localparam int PSEL_MSB   = 2;
   // Options field positions
   localparam int TRE_BIT    = 0;
   localparam int TRH_BIT    = 1;
   localparam int ADCEN_BIT  = 2;
   localparam int KEYEN_LSB  = 4;
   // Power command codes
   localparam logic [1:0] CMD_LIGHT = 2'h1;
   localparam logic [1:0] CMD_DEEP  = 2'h2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Timing
   localparam int CLK_HZ      = 100_000_000;
   localparam int LFO_HZ      = 1_000;
   localparam int BASE_MS     = 2;
   localparam int LFO_TICKS_PER_MS = LFO_HZ / 1000;
   localparam int TEMP_CHANNEL = 1;
   typedef enum logic [1:0] {MODE_RUN, MODE_LIGHT, MODE_DEEP} power_mode_type;
   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } axil_req_type;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } axil_rsp_type;
endpackage
